// *** design/conv_power_ctrl.sv ***
// Purpose: conversion start, busy, power-down and global reset sequencing
// Assumes: all pin inputs asynchronous; host waits for busy low
// Notes:   conversion length is a timer standing in for the converter core
//
// Behaviour
// - Start rising edge holds samplers, starts conversion
// - Start acts regardless of chip select
// - Busy rises at each conversion start
// - Busy stays high until conversion ends
// - Power-down high ignores further start requests
// - Power-down mid-conversion waits for completion
// - Two power-downs without conversion cause reset
// - All four channels sampled at one instant
// - Busy falling forces forwarded clock low
// - Bus active only with chip select low
`timescale 1ns/1ps
module conv_power_ctrl
    import conv_ctrl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,
    parameter int RESET_LEN = GRESET_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic convert_start,
    input wire logic power_down_request,
    input wire logic cs_n,
    input wire logic shift_clock_in,
    input wire logic io_mode_select,
    output logic busy,
    output logic [NUM_CHANNELS-1:0] sample_hold,
    output logic conversion_done,
    output logic powered_down,
    output logic global_reset,
    output logic forwarded_shift_clock,
    output logic serial_bus_enable,
    output logic shift_clock_enable,
    output logic io_mode_differential
);

    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_LEN - 1);
    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_LEN - 1);

    typedef struct packed {
        ctrl_state_t state;
        logic [CNT_W-1:0] count;
        logic pd_pending;      // Power-down asked during a conversion
        logic pd_armed;        // One power-down seen since last conversion
        logic busy;
        logic [NUM_CHANNELS-1:0] hold;
        logic done;
        logic pwr_dn;
        logic greset;
        logic fwd_clk;
        logic bus_en;
        logic sck_en;
        logic lvds;
    } ctrl_reg_t;

    ctrl_reg_t st_reg;
    ctrl_reg_t st_next;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync_if #(.WIDTH(PIN_COUNT)) pins ();

    // Raw pins into the synchroniser lanes
    assign pins.raw[PIN_CONV] = convert_start;
    assign pins.raw[PIN_PWRDN] = power_down_request;
    // Select lane is inverted so its reset value matches an idle bus
    assign pins.raw[PIN_CS_N] = ~cs_n;
    assign pins.raw[PIN_SCK] = shift_clock_in;
    assign pins.raw[PIN_LVDS] = io_mode_select;

    pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .pins(pins)
    );

    logic conv_rise;
    logic pd_rise;
    logic pd_level;
    logic bus_sel;
    logic sck_rise;

    // Decoded pin events
    assign conv_rise = pins.rise[PIN_CONV];
    assign pd_rise = pins.rise[PIN_PWRDN];
    assign pd_level = pins.level[PIN_PWRDN];
    assign bus_sel = pins.level[PIN_CS_N];
    assign sck_rise = pins.rise[PIN_SCK];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.greset = 1'b0;
        // Strap is static; follow it so a late settle is still seen
        st_next.lvds = pins.level[PIN_LVDS];
        // Bus and shift clock gated purely by chip select
        st_next.bus_en = bus_sel;
        st_next.sck_en = bus_sel;

        // Forwarded clock: half rate in CMOS, copy in differential mode
        if (st_reg.busy || !bus_sel)
        begin
            st_next.fwd_clk = 1'b0;
        end
        else if (st_reg.lvds)
        begin
            st_next.fwd_clk = pins.level[PIN_SCK];
        end
        else if (sck_rise)
        begin
            st_next.fwd_clk = ~st_reg.fwd_clk;
        end

        case (st_reg.state)
            ST_IDLE:
            begin
                // Start is not qualified by chip select
                if (pd_rise && st_reg.pd_armed)
                begin
                    st_next.state = ST_GLOBAL_RESET;
                    st_next.count = '0;
                    st_next.greset = 1'b1;
                end
                else if (pd_level)
                begin
                    st_next.state = ST_POWERED_DOWN;
                    st_next.pwr_dn = 1'b1;
                    st_next.pd_armed = 1'b1;
                end
                else if (conv_rise)
                begin
                    st_next.state = ST_CONVERT;
                    st_next.count = '0;
                    st_next.busy = 1'b1;
                    st_next.hold = '1;
                end
            end
            ST_CONVERT:
            begin
                // Late start edges are dropped; host must wait
                if (pd_rise)
                begin
                    st_next.pd_pending = 1'b1;
                end
                if (st_reg.count == CONV_LAST)
                begin
                    st_next.busy = 1'b0;
                    st_next.hold = '0;
                    st_next.done = 1'b1;
                    st_next.fwd_clk = 1'b0;
                    st_next.pd_armed = 1'b0;
                    st_next.pd_pending = 1'b0;
                    if (st_reg.pd_pending || pd_rise || pd_level)
                    begin
                        st_next.state = ST_POWERED_DOWN;
                        st_next.pwr_dn = 1'b1;
                        st_next.pd_armed = 1'b1;
                    end
                    else
                    begin
                        st_next.state = ST_IDLE;
                    end
                end
                else
                begin
                    st_next.count = st_reg.count + CNT_W'(1);
                end
            end
            ST_POWERED_DOWN:
            begin
                // Start edges ignored while down
                if (!pd_level)
                begin
                    st_next.state = ST_IDLE;
                    st_next.pwr_dn = 1'b0;
                end
            end
            ST_GLOBAL_RESET:
            begin
                // Clear busy, hold and power-down flags as power-on does; strap, bus enables and forwarded clock run on
                st_next.greset = 1'b1;
                st_next.pd_armed = 1'b0;
                st_next.pd_pending = 1'b0;
                st_next.busy = 1'b0;
                st_next.hold = '0;
                st_next.pwr_dn = 1'b0;
                if (st_reg.count == RESET_LAST)
                begin
                    st_next.greset = 1'b0;
                    st_next.state = ST_IDLE;
                end
                else
                begin
                    st_next.count = st_reg.count + CNT_W'(1);
                end
            end
            default:
            begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    // Registered state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign busy = st_reg.busy;
    assign sample_hold = st_reg.hold;
    assign conversion_done = st_reg.done;
    assign powered_down = st_reg.pwr_dn;
    assign global_reset = st_reg.greset;
    assign forwarded_shift_clock = st_reg.fwd_clk;
    assign serial_bus_enable = st_reg.bus_en;
    assign shift_clock_enable = st_reg.sck_en;
    assign io_mode_differential = st_reg.lvds;

endmodule : conv_power_ctrl

// *** design/conv_ctrl_pkg.sv ***
// Purpose: shared constants and types for the conversion control block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   conversion and reset lengths are plain defaults, not measured
package conv_ctrl_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 2000;        // Least conversion time
    localparam int GRESET_TIME_NS = 1000;      // Internal reset length
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GRESET_CYCLES =
        (GRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Pin synchroniser lane positions
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int PIN_CONV = 0;
    localparam int PIN_PWRDN = 1;
    localparam int PIN_CS_N = 2;
    localparam int PIN_SCK = 3;
    localparam int PIN_LVDS = 4;

    localparam int NUM_CHANNELS = 4;

    // ------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_POWERED_DOWN = 2'b10,
        ST_GLOBAL_RESET = 2'b11
    } ctrl_state_t;

endpackage : conv_ctrl_pkg

// *** design/pin_sync_if.sv ***
// Purpose: carries raw pins and their synchronised forms
// Assumes: all lanes belong to the one clock domain
// Notes:   rise is a one-cycle pulse per lane
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;

    modport sync (input raw, output level, output rise);
    modport user (output raw, input level, input rise);
endinterface : pin_sync_if

// *** design/pin_sync.sv ***
// Purpose: two-flop synchroniser with rising-edge detect per lane
// Assumes: raw lanes are asynchronous to clk
// Notes:   edge logic only looks at the second stage and beyond
`timescale 1ns/1ps
module pin_sync
    import conv_ctrl_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst,
    pin_sync_if.sync pins
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // ------------------------------------------------------------
    // Next state: shift chain; first stage feeds only the second
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.meta = pins.raw;
        st_next.stable = st_reg.meta;
        st_next.prev = st_reg.stable;
    end

    // Registered state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs taken from stages two and three
    assign pins.level = st_reg.stable;
    assign pins.rise = st_reg.stable & ~st_reg.prev;

endmodule : pin_sync

// *** dv/conv_power_ctrl_properties.sv ***
// Purpose: timing checks on the conversion control pins
// Assumes: one clock, rst synchronous active high
// Notes:   pulse lengths come from the instance parameters
`timescale 1ns/1ps
module conv_power_ctrl_properties
    import conv_ctrl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,
    parameter int RESET_LEN = GRESET_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic convert_start,
    input wire logic power_down_request,
    input wire logic cs_n,
    input wire logic shift_clock_in,
    input wire logic io_mode_select,
    input wire logic busy,
    input wire logic [NUM_CHANNELS-1:0] sample_hold,
    input wire logic conversion_done,
    input wire logic powered_down,
    input wire logic global_reset,
    input wire logic forwarded_shift_clock,
    input wire logic serial_bus_enable,
    input wire logic shift_clock_enable,
    input wire logic io_mode_differential
);
    logic [7:0] busy_cnt_reg;
    logic [7:0] gr_cnt_reg;

    // Run lengths; cleared whenever the level drops, so no reset needed
    always_ff @(posedge clk)
    begin
        busy_cnt_reg <= busy ? busy_cnt_reg + 8'h01 : 8'h00;
        gr_cnt_reg <= global_reset ? gr_cnt_reg + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Start edge seen while fully idle, then busy within sync delay
    sequence s_idle_start;
        $rose(convert_start) && !busy && !powered_down && !global_reset
            && !power_down_request;
    endsequence
    sequence s_busy_rise;
        ##[1:4] $rose(busy);
    endsequence

    a_start_busy: assert property (s_idle_start |-> s_busy_rise)
        else $error("start edge not answered by busy");
    a_busy_length: assert property (
        $fell(busy) |-> busy_cnt_reg == CONV_LEN)
        else $error("busy length wrong");
    a_done_pulse: assert property (
        conversion_done |-> $fell(busy) ##1 !conversion_done)
        else $error("done pulse misplaced");
    a_hold_all: assert property (sample_hold == {NUM_CHANNELS{busy}})
        else $error("sample hold not matching busy");
    a_fwd_low: assert property (
        $fell(busy) |-> !forwarded_shift_clock)
        else $error("forwarded clock high at busy fall");
    a_pd_waits: assert property (busy |-> !powered_down)
        else $error("powered down during conversion");
    a_pd_blocks: assert property (
        powered_down && power_down_request |=> !$rose(busy))
        else $error("conversion while powered down");
    a_cs_gate: assert property (
        cs_n [*5] |-> !serial_bus_enable && !shift_clock_enable)
        else $error("bus enabled with chip select high");
    a_reset_len: assert property (
        $fell(global_reset) |-> gr_cnt_reg == RESET_LEN)
        else $error("global reset length wrong");
endmodule : conv_power_ctrl_properties

bind conv_power_ctrl conv_power_ctrl_properties #(
    .CONV_LEN(CONV_LEN),
    .RESET_LEN(RESET_LEN)
) u_props (.*);

// *** dv/host_model.sv ***
// Purpose: host side that pulses the start pin and runs the shift clock
// Assumes: shares clk with the block
// Notes:   rude skips the busy wait, only to provoke a refusal
`timescale 1ns/1ps
module host_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic rude,
    input wire logic cs_n,
    input wire logic busy,
    output logic convert_start,
    output logic shift_clock_in
);
    logic [2:0] pulse_reg;
    logic [2:0] div_reg;

    // Start pulse held four cycles so the synchroniser cannot miss it
    always_ff @(posedge clk)
    begin
        if (rst)
            pulse_reg <= 3'h0;
        else if (pulse_reg != 3'h0)
            pulse_reg <= pulse_reg - 3'h1;
        else if (go && (rude || !busy))
            pulse_reg <= 3'h4;
    end
    assign convert_start = (pulse_reg != 3'h0);

    // Shift clock stands low outside frames, four cycles per phase
    always_ff @(posedge clk)
    begin
        if (rst || cs_n)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end
    assign shift_clock_in = div_reg[2];
endmodule : host_model

// *** dv/tb_adc_conversion_power_control.sv ***
// Purpose: self-checking bench for the conversion control block
// Assumes: short conversion and reset counts
// Notes:   drives and samples 1 ns after the rising edge
`timescale 1ns/1ps
module tb_adc_conversion_power_control
    import conv_ctrl_pkg::*;
;
    localparam int CL = 8;
    localparam int RL = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic rude = 1'b0;
    logic pd = 1'b0;
    logic cs_n = 1'b1;
    logic mode = 1'b0;
    logic start, sck, busy, done, pdn, grst, fwd, sbe, sce, diff;
    logic [NUM_CHANNELS-1:0] hold;
    int err_count = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    host_model host_u (.clk(clk), .rst(rst), .go(go), .rude(rude),
        .cs_n(cs_n), .busy(busy), .convert_start(start),
        .shift_clock_in(sck));
    conv_power_ctrl #(.CONV_LEN(CL), .RESET_LEN(RL)) dut_u (.clk(clk),
        .rst(rst), .convert_start(start), .power_down_request(pd),
        .cs_n(cs_n), .shift_clock_in(sck), .io_mode_select(mode),
        .busy(busy), .sample_hold(hold), .conversion_done(done),
        .powered_down(pdn), .global_reset(grst),
        .forwarded_shift_clock(fwd), .serial_bus_enable(sbe),
        .shift_clock_enable(sce), .io_mode_differential(diff));

    task tick;
        @(posedge clk);
        #1;
    endtask : tick

    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task summarize;
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Ask the host for a start pulse; r skips its busy wait
    task req(input logic r);
        go <= 1'b1;
        rude <= r;
        tick;
        go <= 1'b0;
        rude <= 1'b0;
    endtask : req

    // Wait for busy rise, then count its length up to the fall
    task conv(output int n);
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            tick;
            n++;
        end
        check(8'(busy), 8'h01);
        check(8'(hold), 8'h0f);
        n = 0;
        while (busy === 1'b1 && n < 50)
        begin
            tick;
            n++;
        end
    endtask : conv

    // Quiet window: no conversion may start
    task quiet;
        logic seen;
        seen = 1'b0;
        repeat (12)
        begin
            tick;
            seen |= busy;
        end
        check(8'(seen), 8'h00);
    endtask : quiet

    task t_conv(input logic cs);
        int n;
        cs_n <= cs;
        req(1'b0);
        conv(n);
        check(8'(n), 8'(CL));
        check(8'(done), 8'h01);
        check(8'(diff), 8'(mode));
        check(8'(fwd), 8'h00);
        tick;
        check(8'(done), 8'h00);
    endtask : t_conv

    // Rude request comes while the first start pulse is still held, so the host drops it; busy length and quiet are checked
    task t_refuse;
        int n;
        req(1'b0);
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            tick;
            n++;
        end
        req(1'b1);
        n = 1;
        while (busy === 1'b1 && n < 50)
        begin
            tick;
            n++;
        end
        check(8'(n), 8'(CL));
        quiet;
    endtask : t_refuse

    task t_pd_mid;
        int n;
        req(1'b0);
        conv(n);
        check(8'(n), 8'(CL));
        check(8'(pdn), 8'h01);
        req(1'b1);
        quiet;
        pd <= 1'b0;
        repeat (6) tick;
        check(8'(pdn), 8'h00);
    endtask : t_pd_mid

    task t_greset;
        int n;
        pd <= 1'b1;
        repeat (6) tick;
        check(8'(pdn), 8'h01);
        pd <= 1'b0;
        repeat (6) tick;
        pd <= 1'b1;
        n = 0;
        while (grst !== 1'b1 && n < 10)
        begin
            tick;
            n++;
        end
        n = 0;
        while (grst === 1'b1 && n < 50)
        begin
            tick;
            n++;
        end
        check(8'(n), 8'(RL));
        pd <= 1'b0;
        repeat (6) tick;
    endtask : t_greset

    task t_cs;
        logic seen;
        cs_n <= 1'b0;
        mode <= 1'b1;
        repeat (5) tick;
        check({6'h00, sbe, sce}, 8'h03);
        check(8'(diff), 8'h01);
        // Selected and idle: forwarded clock must follow the shift clock
        seen = 1'b0;
        repeat (16)
        begin
            tick;
            seen |= fwd;
        end
        check(8'(seen), 8'h01);
        cs_n <= 1'b1;
        repeat (5) tick;
        check({6'h00, sbe, sce}, 8'h00);
        check(8'(fwd), 8'h00);
    endtask : t_cs

    // Main sequence; pd is raised mid conversion by a branch forked beside t_pd_mid
    initial
    begin
        repeat (5) tick;
        rst <= 1'b0;
        repeat (3) tick;
        t_conv(1'b1);
        t_conv(1'b0);
        t_refuse;
        fork
            t_pd_mid;
            begin
                repeat (6) tick;
                pd <= 1'b1;
            end
        join
        t_conv(1'b0);
        t_greset;
        t_cs;
        t_conv(1'b1);
        summarize;
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        #50000;
        err_count++;
        summarize;
    end
endmodule : tb_adc_conversion_power_control
